// *** logic/cfg_pkg.sv ***
package cfg_pkg;
   // Register offsets on the serial control port
   localparam logic [12:0] OFS_PORT_CFG    = 13'h0000;
   localparam logic [12:0] OFS_CONV_SELECT = 13'h0005;
   localparam logic [12:0] OFS_RX_OFFSET   = 13'h0010;
   localparam logic [12:0] OFS_FILTER_CTRL = 13'h0030;
   localparam logic [12:0] OFS_TX_IFACE    = 13'h0031;
   localparam logic [12:0] OFS_UPDATE      = 13'h00FF;

   // Reset values
   localparam logic [7:0] RST_FILTER_CTRL = 8'h00;
   localparam logic [7:0] RST_TX_IFACE    = 8'h00;
   localparam logic [5:0] RST_RX_OFFSET   = 6'h00;
   localparam logic [1:0] RST_CONV_SELECT = 2'h0;

   // Filter and port control fields
   localparam int FC_DECIMATOR_BYPASS   = 5;
   localparam int FC_HB2_BP   = 4;
   localparam int FC_HB1_BP   = 3;
   localparam int FC_RC_BP    = 2;
   localparam int FC_TX_DATA_CLOCK_GATE = 1;
   localparam int FC_DIR      = 0;
   localparam logic [7:0] FC_USED_MASK = 8'h3F;

   // Transmit interface fields
   localparam int TI_SDR      = 7;
   localparam int TI_INV      = 6;
   localparam int TI_MODE_HI  = 5;
   localparam int TI_MODE_LO  = 4;

   // Port configuration: soft reset bit and its mirror
   localparam int PC_SRST     = 5;
   localparam int PC_SRST_MIR = 2;

   // Clock pin modes
   localparam logic [1:0] CKMD_OFF = 2'h0;
   localparam logic [1:0] CKMD_IN  = 2'h1;
   localparam logic [1:0] CKMD_TXP = 2'h2;
   localparam logic [1:0] CKMD_DLL = 2'h3;

   // Serial frame
   localparam logic [4:0] HDR_LAST  = 5'h0F;
   localparam logic [4:0] DATA_LAST = 5'h07;

   typedef enum logic [1:0]
   {
      SP_IDLE = 2'h0,
      SP_HDR  = 2'h1,
      SP_DATA = 2'h3,
      SP_DONE = 2'h2
   } spi_state_e;
endpackage

// *** logic/filter_bypass_tx_clock_config.sv ***
`timescale 1ns/10ps
// Function
// - Add signed offset to addressed receive converter
// - Apply new offset only after update edge
// - Offset field decoded as two's complement
// - Bit 5 routes receive around decimator
// - Bit 4 bypasses second half-band stage
// - Bit 3 bypasses first half-band stage
// - Bit 2 bypasses raised cosine stage
// - Stages cascade raised cosine, first, second
// - Raised cosine enabled forces both half-bands
// - Bit 1 enables transmit data clocks
// - Bit 0 selects shared port direction
// - Bit 7 selects single-edge, else DDR
// - Bit 6 inverts driven transmit clock
// - Pin mode: off, input, path, DLL
// - Half-duplex one-clock: clock on shared pin while bit 0 is clear, else on neither pin
// - Other modes: clock on dedicated pin
module filter_bypass_tx_clock_config #(
   parameter int SAMPLE_W = 12
)(
   input  wire logic                REF_CLK,
   input  wire logic                RSTN,
   input  wire logic                CSB_N,
   input  wire logic                SCLK,
   input  wire logic                SDI,
   output logic                     SDO_O,
   output logic                     SDO_OE,
   input  wire logic [SAMPLE_W-1:0] RX_I_IN,
   input  wire logic [SAMPLE_W-1:0] RX_Q_IN,
   output logic [SAMPLE_W-1:0]      RX_I_OUT,
   output logic [SAMPLE_W-1:0]      RX_Q_OUT,
   output logic                     DECIMATOR_BYPASS,
   output logic                     RAISED_COSINE_EN,
   output logic                     FIRST_HALFBAND_EN,
   output logic                     SECOND_HALFBAND_EN,
   output logic                     TX_DATA_CLOCK_GATE,
   output logic                     PORT_DIRECTION_SELECT,
   output logic                     TX_SINGLE_EDGE_SELECT,
   input  wire logic                HALF_DUPLEX,
   input  wire logic                ONE_CLOCK_MODE,
   input  wire logic                TX_PATH_CLK,
   input  wire logic                DLL_CLK,
   input  wire logic                TX_CLOCK_PIN_I,
   output logic                     TX_CLOCK_PIN_O,
   output logic                     TX_CLOCK_PIN_OE,
   output logic                     SHARED_PORT_CLOCK_PIN_O,
   output logic                     SHARED_PORT_CLOCK_PIN_OE,
   output logic                     TX_CLOCK_FROM_PIN,
   output logic                     TX_CLOCK_FROM_PIN_VAL
);
   // Offset field is six bits wide and the sample must hold it; wider paths are not served
   if (SAMPLE_W < 7 || SAMPLE_W > 16)
   begin : g_width_check
      $error("SAMPLE_W must lie between 7 and 16");
   end

   function automatic logic [SAMPLE_W-1:0] add_offset(input logic [SAMPLE_W-1:0] s, input logic [5:0] o);
      logic [SAMPLE_W-1:0] ext;
      ext = {{(SAMPLE_W-6){o[5]}}, o};
      return s + ext;
   endfunction

   logic       rst_s1_r;
   logic       rst_n_r;
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Serial control port, oversampled by REF_CLK
   cfg_pkg::spi_state_e state_r;
   logic        sclk_d_r;
   logic [4:0]  cnt_r;
   logic [15:0] hdr_r;
   logic [7:0]  sh_r;
   logic        wr_pulse_r;
   logic [12:0] addr_r;
   logic [7:0]  wdata_r;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [7:0]  rdata;

   logic [7:0]  port_cfg_r;
   logic [1:0]  conv_sel_r;
   logic [5:0]  offset_r;
   logic        update_r;
   logic [7:0]  filter_r;
   logic [7:0]  tx_if_r;
   logic [5:0]  off_i_r;
   logic [5:0]  off_q_r;
   logic        soft_rst;

   assign sclk_rise = SCLK & ~sclk_d_r;
   assign sclk_fall = ~SCLK & sclk_d_r;

   always_comb
   begin
      case (addr_r)
         cfg_pkg::OFS_PORT_CFG:    rdata = port_cfg_r;
         cfg_pkg::OFS_CONV_SELECT: rdata = {6'h00, conv_sel_r};
         cfg_pkg::OFS_RX_OFFSET:   rdata = {2'h0, offset_r};
         cfg_pkg::OFS_FILTER_CTRL: rdata = filter_r & cfg_pkg::FC_USED_MASK;
         cfg_pkg::OFS_TX_IFACE:    rdata = tx_if_r;
         cfg_pkg::OFS_UPDATE:      rdata = {7'h00, update_r};
         default:                  rdata = 8'h00;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r    <= cfg_pkg::SP_IDLE;
         sclk_d_r   <= 1'b0;
         cnt_r      <= 5'h00;
         hdr_r      <= 16'h0000;
         sh_r       <= 8'h00;
         wr_pulse_r <= 1'b0;
         addr_r     <= 13'h0000;
         wdata_r    <= 8'h00;
      end
      else
      begin
         sclk_d_r   <= SCLK;
         wr_pulse_r <= 1'b0;
         if (CSB_N)
         begin
            state_r <= cfg_pkg::SP_IDLE;
            cnt_r   <= 5'h00;
         end
         else
         begin
            case (state_r)
               cfg_pkg::SP_IDLE:
                  state_r <= cfg_pkg::SP_HDR;
               cfg_pkg::SP_HDR:
                  if (sclk_rise)
                  begin
                     hdr_r <= {hdr_r[14:0], SDI};
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == cfg_pkg::HDR_LAST)
                     begin
                        addr_r  <= {hdr_r[11:0], SDI};
                        cnt_r   <= 5'h00;
                        state_r <= cfg_pkg::SP_DATA;
                     end
                  end
               cfg_pkg::SP_DATA:
                  if (sclk_rise)
                  begin
                     sh_r  <= {sh_r[6:0], SDI};
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == cfg_pkg::DATA_LAST)
                     begin
                        wdata_r    <= {sh_r[6:0], SDI};
                        wr_pulse_r <= ~hdr_r[15];
                        state_r    <= cfg_pkg::SP_DONE;
                     end
                  end
               cfg_pkg::SP_DONE:
                  state_r <= cfg_pkg::SP_DONE;
               default:
                  state_r <= cfg_pkg::SP_IDLE;
            endcase
         end
      end
   end

   // Read data leaves MSB first; each bit changes on a falling SCLK edge
   logic [7:0] rd_sh_r;
   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rd_sh_r <= 8'h00;
         SDO_O   <= 1'b0;
         SDO_OE  <= 1'b0;
      end
      else
      begin
         SDO_OE <= !CSB_N && state_r == cfg_pkg::SP_DATA && hdr_r[15];
         if (state_r == cfg_pkg::SP_HDR && sclk_rise && cnt_r == cfg_pkg::HDR_LAST)
            rd_sh_r <= 8'h00;
         else if (state_r == cfg_pkg::SP_DATA && sclk_fall)
         begin
            SDO_O   <= (cnt_r == 5'h00) ? rdata[7] : rd_sh_r[7];
            rd_sh_r <= (cnt_r == 5'h00) ? {rdata[6:0], 1'b0} : {rd_sh_r[6:0], 1'b0};
         end
      end
   end

   // Soft reset on a rising edge of the port-config reset bit; that register itself survives
   assign soft_rst = wr_pulse_r && addr_r == cfg_pkg::OFS_PORT_CFG &&
                     wdata_r[cfg_pkg::PC_SRST] && !port_cfg_r[cfg_pkg::PC_SRST];

   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
         port_cfg_r <= 8'h00;
      else if (wr_pulse_r && addr_r == cfg_pkg::OFS_PORT_CFG)
         port_cfg_r <= wdata_r;
   end

   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         conv_sel_r <= cfg_pkg::RST_CONV_SELECT;
         offset_r   <= cfg_pkg::RST_RX_OFFSET;
         update_r   <= 1'b0;
         filter_r   <= cfg_pkg::RST_FILTER_CTRL;
         tx_if_r    <= cfg_pkg::RST_TX_IFACE;
         off_i_r    <= cfg_pkg::RST_RX_OFFSET;
         off_q_r    <= cfg_pkg::RST_RX_OFFSET;
      end
      else if (soft_rst)
      begin
         conv_sel_r <= cfg_pkg::RST_CONV_SELECT;
         offset_r   <= cfg_pkg::RST_RX_OFFSET;
         update_r   <= 1'b0;
         filter_r   <= cfg_pkg::RST_FILTER_CTRL;
         tx_if_r    <= cfg_pkg::RST_TX_IFACE;
         off_i_r    <= cfg_pkg::RST_RX_OFFSET;
         off_q_r    <= cfg_pkg::RST_RX_OFFSET;
      end
      else if (wr_pulse_r)
      begin
         case (addr_r)
            cfg_pkg::OFS_CONV_SELECT: conv_sel_r <= wdata_r[1:0];
            cfg_pkg::OFS_RX_OFFSET:   offset_r   <= wdata_r[5:0];
            cfg_pkg::OFS_FILTER_CTRL: filter_r   <= wdata_r & cfg_pkg::FC_USED_MASK;
            cfg_pkg::OFS_TX_IFACE:    tx_if_r    <= wdata_r;
            cfg_pkg::OFS_UPDATE:
            begin
               update_r <= wdata_r[0];
               if (wdata_r[0] && !update_r)
               begin
                  if (conv_sel_r[0])
                     off_i_r <= offset_r;
                  if (conv_sel_r[1])
                     off_q_r <= offset_r;
               end
            end
            default:
               update_r <= update_r;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         RX_I_OUT <= '0;
         RX_Q_OUT <= '0;
      end
      else
      begin
         RX_I_OUT <= add_offset(RX_I_IN, off_i_r);
         RX_Q_OUT <= add_offset(RX_Q_IN, off_q_r);
      end
   end

   // Filter chain runs raised cosine, then first, then second half-band
   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         DECIMATOR_BYPASS      <= 1'b0;
         RAISED_COSINE_EN      <= 1'b1;
         FIRST_HALFBAND_EN     <= 1'b1;
         SECOND_HALFBAND_EN    <= 1'b1;
         TX_DATA_CLOCK_GATE    <= 1'b0;
         PORT_DIRECTION_SELECT <= 1'b0;
         TX_SINGLE_EDGE_SELECT <= 1'b0;
      end
      else
      begin
         DECIMATOR_BYPASS   <= filter_r[cfg_pkg::FC_DECIMATOR_BYPASS];
         RAISED_COSINE_EN   <= !filter_r[cfg_pkg::FC_RC_BP];
         FIRST_HALFBAND_EN  <= !filter_r[cfg_pkg::FC_HB1_BP] || !filter_r[cfg_pkg::FC_RC_BP];
         SECOND_HALFBAND_EN <= !filter_r[cfg_pkg::FC_HB2_BP] || !filter_r[cfg_pkg::FC_RC_BP];
         TX_DATA_CLOCK_GATE    <= filter_r[cfg_pkg::FC_TX_DATA_CLOCK_GATE];
         PORT_DIRECTION_SELECT <= filter_r[cfg_pkg::FC_DIR];
         TX_SINGLE_EDGE_SELECT <= tx_if_r[cfg_pkg::TI_SDR];
      end
   end

   // Clock pins are sampled levels here, so the driven clock lags its source by one REF_CLK
   logic [1:0] ck_mode;
   logic       ck_src;
   logic       ck_drive;
   logic       on_shared;
   assign ck_mode   = tx_if_r[cfg_pkg::TI_MODE_HI:cfg_pkg::TI_MODE_LO];
   assign ck_src    = ((ck_mode == cfg_pkg::CKMD_DLL) ? DLL_CLK : TX_PATH_CLK) ^ tx_if_r[cfg_pkg::TI_INV];
   assign ck_drive  = ck_mode == cfg_pkg::CKMD_TXP || ck_mode == cfg_pkg::CKMD_DLL;
   assign on_shared = HALF_DUPLEX && ONE_CLOCK_MODE;

   always_ff @(posedge REF_CLK or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         TX_CLOCK_PIN_O           <= 1'b0;
         TX_CLOCK_PIN_OE          <= 1'b0;
         SHARED_PORT_CLOCK_PIN_O  <= 1'b0;
         SHARED_PORT_CLOCK_PIN_OE <= 1'b0;
         TX_CLOCK_FROM_PIN        <= 1'b0;
         TX_CLOCK_FROM_PIN_VAL    <= 1'b0;
      end
      else
      begin
         TX_CLOCK_PIN_O           <= ck_src;
         TX_CLOCK_PIN_OE          <= ck_drive && !on_shared;
         SHARED_PORT_CLOCK_PIN_O  <= ck_src;
         SHARED_PORT_CLOCK_PIN_OE <= ck_drive && on_shared && !filter_r[cfg_pkg::FC_DIR];
         TX_CLOCK_FROM_PIN        <= ck_mode == cfg_pkg::CKMD_IN;
         TX_CLOCK_FROM_PIN_VAL    <= TX_CLOCK_PIN_I;
      end
   end
endmodule

// *** testbench/cfg_checker_sva.sv ***
`timescale 1ns/10ps
module cfg_checker #(
   parameter int SAMPLE_W = 12
)(
   input wire logic                REF_CLK,
   input wire logic                RSTN,
   input wire logic                CSB_N,
   input wire logic                SDO_OE,
   input wire logic [SAMPLE_W-1:0] RX_I_IN,
   input wire logic [SAMPLE_W-1:0] RX_I_OUT,
   input wire logic                DECIMATOR_BYPASS,
   input wire logic                RAISED_COSINE_EN,
   input wire logic                FIRST_HALFBAND_EN,
   input wire logic                SECOND_HALFBAND_EN,
   input wire logic                TX_DATA_CLOCK_GATE,
   input wire logic                PORT_DIRECTION_SELECT,
   input wire logic                TX_SINGLE_EDGE_SELECT,
   input wire logic                HALF_DUPLEX,
   input wire logic                ONE_CLOCK_MODE,
   input wire logic                TX_CLOCK_PIN_I,
   input wire logic                TX_CLOCK_PIN_OE,
   input wire logic                SHARED_PORT_CLOCK_PIN_OE,
   input wire logic                TX_CLOCK_FROM_PIN,
   input wire logic                TX_CLOCK_FROM_PIN_VAL
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   a_cosine_forces_halfbands: assert property (RAISED_COSINE_EN |-> FIRST_HALFBAND_EN && SECOND_HALFBAND_EN)
      else $error("half-band stage off while raised cosine stage on");
   a_one_clock_pin: assert property (1'b1 |-> !(TX_CLOCK_PIN_OE && SHARED_PORT_CLOCK_PIN_OE))
      else $error("transmit clock driven on both pins");
   a_shared_needs_mode: assert property (SHARED_PORT_CLOCK_PIN_OE |-> $past(HALF_DUPLEX && ONE_CLOCK_MODE))
      else $error("shared pin driven outside half-duplex one-clock mode");
   a_input_not_driven: assert property (TX_CLOCK_FROM_PIN |-> !TX_CLOCK_PIN_OE)
      else $error("transmit clock pin driven while set as input");
   a_pin_level_follows: assert property (TX_CLOCK_FROM_PIN && $past(TX_CLOCK_FROM_PIN)
      |-> TX_CLOCK_FROM_PIN_VAL == $past(TX_CLOCK_PIN_I))
      else $error("input clock level not passed through");
   // Offset only moves through a frame, so between frames the gap out-in is constant
   a_offset_held: assert property (CSB_N [*8] |-> SAMPLE_W'(RX_I_OUT - $past(RX_I_IN))
      == SAMPLE_W'($past(RX_I_OUT) - $past(RX_I_IN, 2)))
      else $error("receive offset changed without an update");
   a_controls_held: assert property (CSB_N [*6] |-> $stable({DECIMATOR_BYPASS, TX_DATA_CLOCK_GATE,
      PORT_DIRECTION_SELECT, TX_SINGLE_EDGE_SELECT}))
      else $error("control level changed between frames");
   a_sdo_quiet: assert property (CSB_N [*3] |-> !SDO_OE)
      else $error("read data driven outside a frame");
endmodule

bind filter_bypass_tx_clock_config cfg_checker #(.SAMPLE_W(SAMPLE_W)) i_chk (.*);

// *** testbench/filter_bypass_tx_clock_config_tb.sv ***
`timescale 1ns/10ps
module filter_bypass_tx_clock_config_tb;
   logic        REF_CLK = 0, RSTN = 0, CSB_N = 1, SCLK = 0, SDI = 0, HALF_DUPLEX = 0, ONE_CLOCK_MODE = 0;
   logic        TX_PATH_CLK = 0, DLL_CLK = 0, TX_CLOCK_PIN_I = 0;
   logic [11:0] RX_I_IN = '0, RX_Q_IN = '0, RX_I_OUT, RX_Q_OUT;
   logic        SDO_O, SDO_OE, DECIMATOR_BYPASS, RAISED_COSINE_EN, FIRST_HALFBAND_EN, SECOND_HALFBAND_EN;
   logic        TX_DATA_CLOCK_GATE, PORT_DIRECTION_SELECT, TX_SINGLE_EDGE_SELECT, TX_CLOCK_PIN_O, TX_CLOCK_PIN_OE;
   logic        SHARED_PORT_CLOCK_PIN_O, SHARED_PORT_CLOCK_PIN_OE, TX_CLOCK_FROM_PIN, TX_CLOCK_FROM_PIN_VAL;
   logic [7:0]  rd;
   int          n_mismatch = 0, tests_run = 0, cycles = 0;
   // Filter write value, then expected {decimator, cosine, half-band 1, half-band 2, gate, direction}
   logic [13:0] rows [9] = '{{8'h3F, 6'h23}, {8'h00, 6'h1C}, {8'h04, 6'h0C}, {8'h1C, 6'h00}, {8'h18, 6'h1C},
                             {8'h14, 6'h08}, {8'h0C, 6'h04}, {8'hC2, 6'h1E}, {8'h21, 6'h3D}};

   filter_bypass_tx_clock_config #(.SAMPLE_W(12)) i_dut (.*);

   initial
   begin
      forever #12.5 REF_CLK = ~REF_CLK;
   end

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge REF_CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge REF_CLK);
      #2;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Slow serial clock: each phase four cycles, well above the two-cycle minimum
   task automatic frame(input logic [23:0] f);
      CSB_N = 0;
      for (int i = 23; i >= 0; i--)
      begin
         SCLK = 0;
         SDI = f[i];
         tick(4);
         if (i < 8)
            rd[i] = SDO_O;
         if (i == 0)
            check(SDO_OE, f[23]);
         SCLK = 1;
         tick(4);
      end
      SCLK = 0;
      tick(4);
      CSB_N = 1;
      tick(6);
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      frame({3'b000, a, d});
   endtask

   task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
      frame({3'b100, a, 8'h00});
      check(rd, exp);
   endtask

   initial
   begin
      tick(2);
      RSTN = 1;
      tick(4);
      check({DECIMATOR_BYPASS, RAISED_COSINE_EN, FIRST_HALFBAND_EN, SECOND_HALFBAND_EN, TX_CLOCK_PIN_OE}, 5'h0E);
      rdc(13'h0031, 8'h00);
      foreach (rows[k])
      begin
         wr(13'h0030, rows[k][13:6]);
         rdc(13'h0030, rows[k][13:6] & 8'h3F);
         check({DECIMATOR_BYPASS, RAISED_COSINE_EN, FIRST_HALFBAND_EN, SECOND_HALFBAND_EN, TX_DATA_CLOCK_GATE,
                PORT_DIRECTION_SELECT}, rows[k][5:0]);
      end
      for (int m = 0; m < 8; m++)
      begin
         wr(13'h0031, {m[2], m[2], m[1:0], 4'h0});
         for (int s = 0; s < 2; s++)
         begin
            TX_PATH_CLK = s[0];
            DLL_CLK = !s[0];
            TX_CLOCK_PIN_I = s[0];
            tick(3);
            check(TX_CLOCK_PIN_OE, m[1]);
            check(TX_CLOCK_FROM_PIN, m[1:0] == 2'h1);
            check(TX_CLOCK_FROM_PIN_VAL, s[0]);
            if (m[1])
               check(TX_CLOCK_PIN_O, (m[0] ? !s[0] : s[0]) ^ m[2]);
         end
         check(TX_SINGLE_EDGE_SELECT, m[2]);
      end
      wr(13'h0031, 8'h20);
      wr(13'h0030, 8'h00);
      HALF_DUPLEX = 1;
      ONE_CLOCK_MODE = 1;
      tick(3);
      check({TX_CLOCK_PIN_OE, SHARED_PORT_CLOCK_PIN_OE}, 2'b01);
      check(SHARED_PORT_CLOCK_PIN_O, 1'b1);
      TX_PATH_CLK = 0;
      tick(2);
      check(SHARED_PORT_CLOCK_PIN_O, 1'b0);
      wr(13'h0030, 8'h01);
      check(SHARED_PORT_CLOCK_PIN_OE, 1'b0);
      ONE_CLOCK_MODE = 0;
      wr(13'h0030, 8'h00);
      check({TX_CLOCK_PIN_OE, SHARED_PORT_CLOCK_PIN_OE}, 2'b10);
      RX_I_IN = 12'd100;
      RX_Q_IN = 12'd100;
      wr(13'h0005, 8'h01);
      wr(13'h0010, 8'h3F);
      check(RX_I_OUT, 12'd100);
      wr(13'h00FF, 8'h00);
      wr(13'h00FF, 8'h01);
      check({RX_I_OUT, 4'h0, RX_Q_OUT}, {12'd99, 4'h0, 12'd100});
      wr(13'h0005, 8'h02);
      wr(13'h0010, 8'h20);
      wr(13'h00FF, 8'h00);
      wr(13'h00FF, 8'h01);
      check({RX_I_OUT, 4'h0, RX_Q_OUT}, {12'd99, 4'h0, 12'd68});
      wr(13'h0040, 8'h55);
      rdc(13'h0040, 8'h00);
      // Soft reset clears the applied offsets as well as the registers
      wr(13'h0000, 8'h24);
      rdc(13'h0031, 8'h00);
      check(RX_Q_OUT, 12'd100);
      wr(13'h0030, 8'h3F);
      RX_I_IN = '0;
      RX_Q_IN = '0;
      tick(2);
      RSTN = 0;
      tick(1);
      check({DECIMATOR_BYPASS, RAISED_COSINE_EN}, 2'b01);
      RSTN = 1;
      tick(4);
      rdc(13'h0030, 8'h00);
      finish_test();
   end
endmodule
